//--- design/pbhh_top.sv
`timescale 1ns/1ps
`default_nettype none
module pbhh_top #(
   parameter int ACC_CYC = 1
) (
   // Clock and reset
   input  wire logic                sys_clk,
   input  wire logic                rst_b,
   // External master handshake
   input  wire logic                bus_release_request_b,
   output var  logic                bus_release_grant_b,
   // Control bit
   input  wire logic                hold_disable,
   // Core access port
   input  wire pbhh_pkg::pbhh_req_t core_req,
   output var  logic                core_stall,
   output var  logic                core_done,
   output var  logic [31:0]         core_rdata,
   // Primary bus pins
   output var  pbhh_pkg::pbhh_pins_t pins,
   input  wire logic [31:0]         bus_data_in
);
   typedef struct packed {
      pbhh_pkg::pbhh_state_t st;
      logic [7:0]            cnt;
      pbhh_pkg::pbhh_req_t   cur;
      pbhh_pkg::pbhh_req_t   pend;
      logic                  grant_b;
      logic                  stall;
      logic                  done;
      logic [31:0]           rdata;
      pbhh_pkg::pbhh_pins_t  pins;
   } pbhh_regs_t;

   pbhh_regs_t r;
   pbhh_regs_t next_r;
   logic       req_sync_b;
   logic       hold_want;

   // Two-flop synchroniser on the pin; adds the possible extra cycle
   pbhh_sync #(.RST_VAL(1'b1)) u_sync (
      .sys_clk  (sys_clk),
      .rst_b    (rst_b),
      .async_in (bus_release_request_b),
      .sync_out (req_sync_b)
   );

   assign hold_want = !req_sync_b && !hold_disable;

   always_comb begin
      next_r      = r;
      next_r.done = 1'b0;
      case (r.st)
         pbhh_pkg::PBHH_IDLE: begin
            next_r.pins.strobe_b = 1'b1;
            next_r.pins.ctl_oe   = 1'b1;
            next_r.pins.data_oe  = 1'b0;
            next_r.stall         = 1'b0;
            if (hold_want) begin
               // No cycle running, so float and grant together
               next_r.st            = pbhh_pkg::PBHH_HOLD;
               next_r.grant_b       = 1'b0;
               next_r.pins.ctl_oe   = 1'b0;
            end else if (r.pend.valid) begin
               next_r.cur        = r.pend;
               next_r.pend.valid = 1'b0;
               next_r.st         = pbhh_pkg::PBHH_ACCESS;
               next_r.cnt        = 8'(ACC_CYC);
               next_r.stall      = 1'b1;
            end else if (core_req.valid) begin
               next_r.cur   = core_req;
               next_r.st    = pbhh_pkg::PBHH_ACCESS;
               next_r.cnt   = 8'(ACC_CYC);
               next_r.stall = 1'b1;
            end
            if (next_r.st == pbhh_pkg::PBHH_ACCESS) begin
               next_r.pins.strobe_b = 1'b0;
               next_r.pins.rw       = !next_r.cur.write;
               next_r.pins.addr     = next_r.cur.addr;
               next_r.pins.data     = next_r.cur.data;
               next_r.pins.data_oe  = next_r.cur.write;
            end
         end
         pbhh_pkg::PBHH_ACCESS: begin
            // Runs to the end even if a hold is wanted meanwhile
            if (r.cnt <= 8'h01) begin
               next_r.st            = pbhh_pkg::PBHH_IDLE;
               next_r.pins.strobe_b = 1'b1;
               next_r.pins.data_oe  = 1'b0;
               next_r.stall         = 1'b0;
               next_r.done          = 1'b1;
               if (!r.cur.write) begin
                  next_r.rdata = bus_data_in;
               end
            end else begin
               next_r.cnt = r.cnt - 8'h01;
            end
         end
         pbhh_pkg::PBHH_HOLD: begin
            next_r.stall = 1'b0;
            if (!hold_want) begin
               // Grant outlasts the request by one cycle
               next_r.st = pbhh_pkg::PBHH_LEAVE;
            end else if (core_req.valid && !core_req.write) begin
               next_r.stall = 1'b1;
            end else if (core_req.valid && core_req.write) begin
               if (r.pend.valid) begin
                  next_r.stall = 1'b1;
               end else begin
                  next_r.pend = core_req;
                  next_r.done = 1'b1;
               end
            end
         end
         pbhh_pkg::PBHH_LEAVE: begin
            next_r.st           = pbhh_pkg::PBHH_IDLE;
            next_r.grant_b      = 1'b1;
            next_r.pins.ctl_oe  = 1'b1;
            next_r.stall        = core_req.valid;
         end
         default: begin
            next_r.st = pbhh_pkg::PBHH_IDLE;
         end
      endcase
      // A disable mid-hold still exits through the leave step
      if (hold_disable && r.st == pbhh_pkg::PBHH_HOLD) begin
         next_r.st = pbhh_pkg::PBHH_LEAVE;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         r              <= '0;
         r.st           <= pbhh_pkg::PBHH_IDLE;
         r.grant_b      <= pbhh_pkg::RST_GRANT;
         r.pins.strobe_b <= 1'b1;
         r.pins.rw      <= 1'b1;
         r.pins.ctl_oe  <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign bus_release_grant_b = r.grant_b;
   assign core_stall          = r.stall;
   assign core_done           = r.done;
   assign core_rdata          = r.rdata;
   assign pins                = r.pins;
endmodule // pbhh_top
`default_nettype wire

//--- design/pbhh_pkg.sv
package pbhh_pkg;

   localparam int ADDR_W_DEF = 24;
   localparam int DATA_W_DEF = 32;
   // Minimum request low time in output clock periods
   localparam int REQ_MIN_LOW_CYC = 2;
   localparam int HOLD_MIN_DEF = REQ_MIN_LOW_CYC;
   localparam logic RST_GRANT = 1'b1;

   typedef enum logic [1:0] {
      PBHH_IDLE,
      PBHH_ACCESS,
      PBHH_HOLD,
      PBHH_LEAVE
   } pbhh_state_t;

   // Request from the core for one primary-bus access
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [23:0] addr;
      logic [31:0] data;
   } pbhh_req_t;

   // Drive side of the shared bus pins
   typedef struct packed {
      logic        strobe_b;
      logic        rw;
      logic [23:0] addr;
      logic [31:0] data;
      logic        ctl_oe;
      logic        data_oe;
   } pbhh_pins_t;

endpackage : pbhh_pkg

//--- design/pbhh_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pbhh_sync #(
   parameter logic RST_VAL = 1'b1
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_b,
   // Asynchronous level in, synchronised level out
   input  wire logic async_in,
   output var  logic sync_out
);
   logic stage1;

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         stage1   <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule // pbhh_sync
`default_nettype wire

//--- testbench/pbhh_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pbhh_chk (
   // Clock and reset
   input wire logic                 sys_clk,
   input wire logic                 rst_b,
   // Handshake, core, pins
   input wire logic                 bus_release_request_b,
   input wire logic                 bus_release_grant_b,
   input wire logic                 hold_disable,
   input wire pbhh_pkg::pbhh_req_t  core_req,
   input wire logic                 core_done,
   input wire pbhh_pkg::pbhh_pins_t pins
);
   wire logic rq = bus_release_request_b;
   wire logic g  = bus_release_grant_b;
   wire logic hd = hold_disable;
   wire logic rd = core_req.valid && !core_req.write;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   property p_sync; $fell(g) |-> !$past(rq, 2); endproperty
   a_sync: assert property (p_sync) else $error("grant without synced request");
   property p_rel; !g && $rose(rq) && !hd |=> !g; endproperty
   a_rel: assert property (p_rel) else $error("grant dropped early");
   property p_dis; $past(hd) && hd && g |=> g; endproperty
   a_dis: assert property (p_dis) else $error("hold while disabled");
   property p_end; !g && hd |-> ##[1:3] g; endproperty
   a_end: assert property (p_end) else $error("hold not ended");
   property p_float; pins.ctl_oe == g && (g || !pins.data_oe); endproperty
   a_float: assert property (p_float) else $error("pins not floated");
   property p_nostart; $fell(pins.strobe_b) |-> g; endproperty
   a_nostart: assert property (p_nostart) else $error("access in hold");
   property p_cmpl; $fell(g) |-> pins.strobe_b; endproperty
   a_cmpl: assert property (p_cmpl) else $error("grant mid cycle");
   property p_rd; !g && rd |=> !core_done; endproperty
   a_rd: assert property (p_rd) else $error("read done in hold");
endmodule // pbhh_chk
bind pbhh_top pbhh_chk u_chk (.sys_clk, .rst_b, .bus_release_request_b, .bus_release_grant_b,
   .hold_disable, .core_req, .core_done, .pins);
`default_nettype wire

//--- testbench/pbhh_master.sv
`timescale 1ns/1ps
`default_nettype none
module pbhh_master (
   // Clock and control
   input  wire logic       sys_clk,
   input  wire logic       go,
   input  wire logic [7:0] len,
   // Request pin
   output var  logic       req_b
);
   logic [7:0] cnt = 8'h00;
   always @(posedge sys_clk) begin
      if (cnt != 8'h00)
         cnt <= cnt - 8'h01;
      else if (go)
         cnt <= (len < 8'h02) ? 8'h02 : len;
   end
   // Skewed off the edge, as a truly asynchronous master would be
   assign #7 req_b = (cnt == 8'h00);
endmodule // pbhh_master
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
   logic                 sys_clk, rst_b, hold_disable, go, w, core_stall, core_done;
   logic                 bus_release_request_b, bus_release_grant_b;
   logic [7:0]           len;
   logic [31:0]          core_rdata, bus_data_in, seed;
   pbhh_pkg::pbhh_req_t  core_req;
   pbhh_pkg::pbhh_pins_t pins;
   int                   mismatches, cmp_count, cyc, i, n;
   pbhh_top u_dut (.sys_clk, .rst_b, .bus_release_request_b, .bus_release_grant_b,
      .hold_disable, .core_req, .core_stall, .core_done, .core_rdata, .pins, .bus_data_in);
   pbhh_master u_mst (.sys_clk, .go, .len, .req_b(bus_release_request_b));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic req(input logic wr);
      @(negedge sys_clk);
      // Writes leave read data alone, so only reads move the bus value
      if (!wr)
         bus_data_in = rnd();
      core_req = {1'b1, wr, seed[23:0], rnd()};
   endtask
   task automatic fin(input int m, input logic e);
      for (n = 0; n < m && core_done !== 1'b1; n++) @(negedge sys_clk);
      `CHK("core_done", e, core_done)
      if (e)
         core_req.valid = 1'b0;
   endtask
   task automatic wrap_up();
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 6000) begin
         mismatches++;
         wrap_up();
      end
   end
   initial begin
      seed = 32'hb8e6_6dbf;
      {rst_b, hold_disable, go, len, bus_data_in, core_req} = '0;
      repeat (4) @(negedge sys_clk);
      rst_b = 1'b1;
      `CHK("reset", 4'b1100, {bus_release_grant_b, pins.ctl_oe, pins.data_oe, core_stall})
      for (i = 0; i < 8; i++) begin
         req(1'b0);
         fin(6, 1'b1);
         `CHK("core_rdata", bus_data_in, core_rdata)
         `CHK("pins_addr_rw", {core_req.addr, 1'b1}, {pins.addr, pins.rw})
         go = 1'b1;
         len = 8'(24 + rnd() % 8);
         w = seed[3];
         req(w);
         fin(6, 1'b1);
         `CHK("core_rdata", bus_data_in, core_rdata)
         go = 1'b0;
         repeat (3) @(negedge sys_clk);
         `CHK("grant", 1'b0, bus_release_grant_b)
         req(w);
         fin(3, w);
         if (w) begin
            req(1'b1);
            fin(3, 1'b0);
         end
         `CHK("core_stall", 1'b1, core_stall)
         fin(60, 1'b1);
         `CHK("grant", 1'b1, bus_release_grant_b)
      end
      hold_disable = 1'b1;
      go = 1'b1;
      len = 8'd20;
      repeat (8) @(negedge sys_clk);
      go = 1'b0;
      `CHK("grant", 1'b1, bus_release_grant_b)
      hold_disable = 1'b0;
      repeat (5) @(negedge sys_clk);
      `CHK("grant", 1'b0, bus_release_grant_b)
      hold_disable = 1'b1;
      repeat (4) @(negedge sys_clk);
      `CHK("grant", 1'b1, bus_release_grant_b)
      repeat (20) @(negedge sys_clk);
      wrap_up();
   end
endmodule // tb
`default_nettype wire
